// ===== hdl/ret_pkg.sv
`default_nettype none
package ret_pkg;
    // Clock rate
    localparam int CLK_MHZ = 25;

    // Event delays in microseconds
    localparam int STAB_US    = 50;
    localparam int TX_IDLE_US = 1234;
    localparam int TX_RX_US   = 192;
    localparam int RX_IDLE_US = 1143;
    localparam int RX_TX_US   = 244;
    localparam int OFF_TX_US  = 147;
    localparam int OFF_RX_US  = 4;
    localparam int WAKE_US    = 210;

    // Delays in clock cycles
    localparam logic [15:0] STAB_CYC    = 16'(STAB_US * CLK_MHZ);
    localparam logic [15:0] TX_IDLE_CYC = 16'(TX_IDLE_US * CLK_MHZ);
    localparam logic [15:0] TX_RX_CYC   = 16'(TX_RX_US * CLK_MHZ);
    localparam logic [15:0] RX_IDLE_CYC = 16'(RX_IDLE_US * CLK_MHZ);
    localparam logic [15:0] RX_TX_CYC   = 16'(RX_TX_US * CLK_MHZ);
    localparam logic [15:0] OFF_TX_CYC  = 16'(OFF_TX_US * CLK_MHZ);
    localparam logic [15:0] OFF_RX_CYC  = 16'(OFF_RX_US * CLK_MHZ);
    localparam logic [15:0] WAKE_CYC    = 16'(WAKE_US * CLK_MHZ);

    // Reference packet layout in bytes
    localparam int BYTE_BITS = 8;
    localparam int HDR_BYTES = 13;
    localparam int LEN_BYTES = 1;
    localparam int CRC_BYTES = 2;

    // Register byte offsets
    localparam logic [7:0] STATUS_ADDR = 8'h00;
    localparam logic [7:0] ENABLE_ADDR = 8'h04;
    localparam logic [7:0] CMD_ADDR    = 8'h08;
    localparam logic [7:0] CONFIG_ADDR = 8'h0c;
    localparam logic [7:0] TRIG_ADDR   = 8'h10;
    localparam logic [7:0] SYMBOL_ADDR = 8'h14;
    localparam logic [7:0] STATE_ADDR  = 8'h18;

    // Command bits
    localparam int CMD_TX_ON  = 0;
    localparam int CMD_RX_ON  = 1;
    localparam int CMD_OFF    = 2;
    localparam int CMD_FORCE  = 3;
    localparam int CMD_SLEEP  = 4;
    localparam int CMD_CAL    = 5;

    // Reset values
    localparam logic [7:0]  EMPTY_TRIG_RST = 8'h02;
    localparam logic [7:0]  FULL_TRIG_RST  = 8'h05;
    localparam logic [7:0]  PAYLOAD_RST    = 8'h18;
    localparam logic [15:0] SYMBOL_RST     = 16'h00fa;

    // Event bit positions
    localparam int EV_STAB = 0;
    localparam int EV_VCO  = 1;
    localparam int EV_PLL  = 2;
    localparam int EV_TRANS = 3;
    localparam int EV_EMPTY = 4;
    localparam int EV_FULL = 5;
    localparam int EV_WAKE = 6;
    localparam int EV_CAL  = 7;
    localparam int EV_RXDONE = 8;
    localparam int EV_CRC  = 9;
    localparam int EV_DIV  = 10;
    localparam int EV_FIFOERR = 12;
    localparam int EV_SYNC = 13;
    localparam int EV_FIELD = 14;
    localparam int EV_SYNCERR = 15;

    localparam int NUM_TMR = 6;

    typedef enum logic [1:0] {
        R_IDLE  = 2'b00,
        R_TX    = 2'b01,
        R_RX    = 2'b11,
        R_SLEEP = 2'b10
    } ret_radio_t;

    typedef enum logic [1:0] {
        FMT_A = 2'b00,
        FMT_B = 2'b01,
        FMT_C = 2'b10,
        FMT_X = 2'b11
    } ret_fmt_t;
endpackage
`default_nettype wire

// ===== hdl/ret_timer_if.sv
`default_nettype none
interface ret_timer_if;
    logic        start;
    logic        tick;
    logic [15:0] load;
    logic        done;
    modport ctl (output start, output tick, output load, input done);
    modport tmr (input start, input tick, input load, output done);
endinterface
`default_nettype wire

// ===== hdl/ret_delay_timer.sv
`default_nettype none
module ret_delay_timer (
    // Clock and reset
    input  wire logic   clock,
    input  wire logic   rst,
    // Control
    ret_timer_if.tmr    t
);
    logic [15:0] count;

    // A restart while running reloads, so the latest reference point wins
    always_ff @(posedge clock) begin
        if (rst) begin
            count <= 16'h0000;
        end else if (t.start) begin
            count <= (t.load == 16'h0000) ? 16'h0001 : t.load;
        end else if (t.tick && count != 16'h0000) begin
            count <= count - 16'h0001;
        end
    end

    assign t.done = t.tick && count == 16'h0001;
endmodule
`default_nettype wire

// ===== hdl/ret_event_ctrl.sv
`default_nettype none
module ret_event_ctrl #(
    parameter logic [15:0] TX_IDLE_CYC = ret_pkg::TX_IDLE_CYC,
    parameter logic [15:0] TX_RX_CYC   = ret_pkg::TX_RX_CYC,
    parameter logic [15:0] RX_IDLE_CYC = ret_pkg::RX_IDLE_CYC,
    parameter logic [15:0] RX_TX_CYC   = ret_pkg::RX_TX_CYC,
    parameter logic [15:0] WAKE_CYC    = ret_pkg::WAKE_CYC
) (
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        rst,
    // APB slave
    input  wire logic [7:0]  paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Radio side status
    input  wire logic        reset_pin_n,
    input  wire logic        power_amp_enable,
    input  wire logic        rxEnable,
    input  wire logic        vcoOutRange,
    input  wire logic        pllUnlock,
    input  wire logic        syncDetect,
    input  wire logic        syncLost,
    input  wire logic        crcBlockDone,
    input  wire logic        crcBad,
    input  wire logic        fieldMatch,
    input  wire logic        fieldMismatch,
    input  wire logic [7:0]  fifoLevel,
    input  wire logic        fifoRead,
    input  wire logic        fifoWrite,
    input  wire logic        fifoOverflow,
    input  wire logic        fifoUnderflow,
    input  wire logic        wakeTimerDone,
    input  wire logic        calTimerDone,
    // Host notification
    output logic             irq_out_n
);
    ret_pkg::ret_radio_t state;
    ret_pkg::ret_radio_t next_state;
    ret_pkg::ret_fmt_t   pktFmt;
    logic [23:0] status;
    logic [23:0] enable;
    logic [23:0] evt;
    logic [23:0] clr;
    logic [1:0]  rx_data_pin_mode;
    logic        divEn;
    logic [7:0]  emptyTrig;
    logic [7:0]  fullTrig;
    logic [7:0]  payloadLen;
    logic [15:0] symPeriod;
    logic [15:0] bitCnt;
    logic        bitTick;
    logic        synced;
    logic        calBusy;
    logic        pinPrev;
    logic        paPrev;
    logic        rxPrev;
    logic [7:0]  levelPrev;
    logic        transStart;
    logic [15:0] transLoad;
    logic        hit;
    logic        wr;
    logic [31:0] rdMux;
    logic        inTx;
    logic        inRx;

    ret_timer_if tmr [ret_pkg::NUM_TMR] ();

    for (genvar i = 0; i < ret_pkg::NUM_TMR; i++) begin : g_tmr
        ret_delay_timer u_tmr (
            .clock (clock),
            .rst   (rst),
            .t     (tmr[i])
        );
    end

    assign inTx = state == ret_pkg::R_TX;
    assign inRx = state == ret_pkg::R_RX;

    // APB: one wait state, since read data and answer come from flops
    assign wr = psel && penable && pready && pwrite;

    always_comb begin
        hit   = 1'b1;
        rdMux = 32'h0000_0000;
        unique case (paddr)
            ret_pkg::STATUS_ADDR: rdMux = {8'h00, status};
            ret_pkg::ENABLE_ADDR: rdMux = {8'h00, enable};
            ret_pkg::CMD_ADDR:    rdMux = 32'h0000_0000;
            ret_pkg::CONFIG_ADDR: rdMux = {27'h0, pktFmt, divEn, rx_data_pin_mode};
            ret_pkg::TRIG_ADDR:   rdMux = {8'h00, payloadLen, fullTrig, emptyTrig};
            ret_pkg::SYMBOL_ADDR: rdMux = {16'h0000, symPeriod};
            ret_pkg::STATE_ADDR:  rdMux = {28'h0, calBusy, synced, state};
            default:              hit = 1'b0;
        endcase
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            pready  <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel && penable && !pready;
            pslverr <= psel && penable && !pready && !hit;
            if (psel && penable && !pready) begin
                prdata <= pwrite ? 32'h0000_0000 : rdMux;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            enable           <= 24'h000000;
            rx_data_pin_mode <= 2'b00;
            divEn            <= 1'b0;
            pktFmt           <= ret_pkg::FMT_A;
            emptyTrig        <= ret_pkg::EMPTY_TRIG_RST;
            fullTrig         <= ret_pkg::FULL_TRIG_RST;
            payloadLen       <= ret_pkg::PAYLOAD_RST;
            symPeriod        <= ret_pkg::SYMBOL_RST;
        end else if (wr) begin
            unique case (paddr)
                ret_pkg::ENABLE_ADDR: enable <= pwdata[23:0];
                ret_pkg::CONFIG_ADDR: begin
                    rx_data_pin_mode <= pwdata[1:0];
                    divEn            <= pwdata[2];
                    pktFmt           <= ret_pkg::ret_fmt_t'(pwdata[4:3]);
                end
                ret_pkg::TRIG_ADDR: begin
                    emptyTrig  <= pwdata[7:0];
                    fullTrig   <= pwdata[15:8];
                    payloadLen <= pwdata[23:16];
                end
                ret_pkg::SYMBOL_ADDR: symPeriod <= pwdata[15:0];
                default: ;
            endcase
        end
    end

    // Command pulses
    logic cmdWr;
    logic txOnCmd;
    logic rxOnCmd;
    logic offCmd;
    assign cmdWr   = wr && paddr == ret_pkg::CMD_ADDR;
    assign txOnCmd = cmdWr && pwdata[ret_pkg::CMD_TX_ON];
    assign rxOnCmd = cmdWr && pwdata[ret_pkg::CMD_RX_ON];
    assign offCmd  = cmdWr && (pwdata[ret_pkg::CMD_OFF] || pwdata[ret_pkg::CMD_FORCE]);

    // Radio state and transition timing
    always_comb begin
        next_state = state;
        transStart = 1'b0;
        transLoad  = ret_pkg::OFF_RX_CYC;
        unique case (state)
            ret_pkg::R_IDLE: begin
                if (txOnCmd) begin
                    next_state = ret_pkg::R_TX;
                    transStart = 1'b1;
                    transLoad  = TX_IDLE_CYC;
                end else if (rxOnCmd) begin
                    next_state = ret_pkg::R_RX;
                    transStart = 1'b1;
                    transLoad  = RX_IDLE_CYC;
                end else if (cmdWr && pwdata[ret_pkg::CMD_SLEEP]) begin
                    next_state = ret_pkg::R_SLEEP;
                end
            end
            ret_pkg::R_TX: begin
                if (rxOnCmd) begin
                    next_state = ret_pkg::R_RX;
                    transStart = 1'b1;
                    transLoad  = RX_TX_CYC;
                end else if (offCmd) begin
                    next_state = ret_pkg::R_IDLE;
                    transStart = 1'b1;
                    transLoad  = ret_pkg::OFF_TX_CYC;
                end
            end
            ret_pkg::R_RX: begin
                if (txOnCmd) begin
                    next_state = ret_pkg::R_TX;
                    transStart = 1'b1;
                    transLoad  = TX_RX_CYC;
                end else if (offCmd) begin
                    next_state = ret_pkg::R_IDLE;
                    transStart = 1'b1;
                    transLoad  = ret_pkg::OFF_RX_CYC;
                end
            end
            ret_pkg::R_SLEEP: begin
                if (wakeTimerDone) begin
                    next_state = ret_pkg::R_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            state <= ret_pkg::R_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // Bit clock from the programmed symbol period
    assign bitTick = bitCnt >= symPeriod - 16'h0001;

    always_ff @(posedge clock) begin
        if (rst || bitTick) begin
            bitCnt <= 16'h0000;
        end else begin
            bitCnt <= bitCnt + 16'h0001;
        end
    end

    // Timer 0: clock stabilization; 1: state transition; 2: RF wake-up;
    // 3: transmit empty; 4: receive full; 5: reception done
    logic pinRise;
    logic wakeRelease;
    assign pinRise     = reset_pin_n && !pinPrev;
    assign wakeRelease = state == ret_pkg::R_SLEEP && wakeTimerDone;

    assign tmr[0].start = pinRise || wakeRelease;
    assign tmr[0].load  = ret_pkg::STAB_CYC;
    assign tmr[0].tick  = 1'b1;
    assign tmr[1].start = transStart;
    assign tmr[1].load  = transLoad;
    assign tmr[1].tick  = 1'b1;
    assign tmr[2].start = txOnCmd && transStart;
    assign tmr[2].load  = WAKE_CYC;
    assign tmr[2].tick  = 1'b1;
    assign tmr[3].start = tmr[2].done;
    assign tmr[3].load  = 16'((ret_pkg::HDR_BYTES + int'(payloadLen) - int'(emptyTrig)) * ret_pkg::BYTE_BITS);
    assign tmr[3].tick  = bitTick;
    assign tmr[4].start = inRx && syncDetect;
    assign tmr[4].load  = 16'(int'(fullTrig) * ret_pkg::BYTE_BITS);
    assign tmr[4].tick  = bitTick;
    assign tmr[5].start = inRx && syncDetect;
    assign tmr[5].load  = 16'((ret_pkg::LEN_BYTES + int'(payloadLen) + ret_pkg::CRC_BYTES) * ret_pkg::BYTE_BITS);
    assign tmr[5].tick  = bitTick;

    always_ff @(posedge clock) begin
        if (rst) begin
            pinPrev   <= 1'b0;
            paPrev    <= 1'b0;
            rxPrev    <= 1'b0;
            levelPrev <= 8'h00;
        end else begin
            pinPrev   <= reset_pin_n;
            paPrev    <= power_amp_enable;
            rxPrev    <= rxEnable;
            levelPrev <= fifoLevel;
        end
    end

    always_ff @(posedge clock) begin
        if (rst || !inRx || syncLost) begin
            synced <= 1'b0;
        end else if (syncDetect) begin
            synced <= 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        if (rst || calTimerDone) begin
            calBusy <= 1'b0;
        end else if (cmdWr && pwdata[ret_pkg::CMD_CAL]) begin
            calBusy <= 1'b1;
        end
    end

    // Event sources
    always_comb begin
        evt = 24'h000000;
        evt[ret_pkg::EV_STAB] = tmr[0].done;
        evt[ret_pkg::EV_VCO] = vcoOutRange && ((inTx && power_amp_enable && !paPrev)
                               || (inRx && rxEnable && !rxPrev));
        evt[ret_pkg::EV_PLL] = pllUnlock && ((inTx && power_amp_enable) || (inRx && rxEnable));
        evt[ret_pkg::EV_TRANS] = tmr[1].done;
        evt[ret_pkg::EV_EMPTY] = (inTx && tmr[3].done)
                                 || (inRx && fifoRead && levelPrev >= emptyTrig && fifoLevel < emptyTrig);
        evt[ret_pkg::EV_FULL] = (inRx && tmr[4].done)
                                || (inTx && fifoWrite && levelPrev <= fullTrig && fifoLevel > fullTrig);
        evt[ret_pkg::EV_WAKE] = wakeRelease;
        evt[ret_pkg::EV_CAL] = calBusy && calTimerDone;
        evt[ret_pkg::EV_RXDONE] = inRx && tmr[5].done;
        evt[ret_pkg::EV_CRC] = crcBad && ((pktFmt == ret_pkg::FMT_C) ? (inRx && tmr[5].done) : crcBlockDone);
        evt[ret_pkg::EV_DIV] = inRx && syncDetect && divEn;
        evt[ret_pkg::EV_FIFOERR] = inRx && (fifoOverflow || fifoUnderflow);
        evt[ret_pkg::EV_SYNC] = inRx && syncDetect;
        evt[ret_pkg::EV_FIELD] = fieldMatch || fieldMismatch;
        evt[ret_pkg::EV_SYNCERR] = inRx && synced && syncLost
                                   && (rx_data_pin_mode == 2'b00 || rx_data_pin_mode == 2'b11);
    end

    // Write one to clear; a new event in the same cycle wins
    assign clr = (wr && paddr == ret_pkg::STATUS_ADDR) ? pwdata[23:0] : 24'h000000;

    always_ff @(posedge clock) begin
        if (rst) begin
            status <= 24'h000000;
        end else begin
            status <= (status & ~clr) | evt;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            irq_out_n <= 1'b1;
        end else begin
            irq_out_n <= !(|(status & enable));
        end
    end

    // Checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    logic [15:0] stabAge;
    logic [15:0] trAge;
    logic [15:0] trLoadReg;
    always_ff @(posedge clock) begin
        if (rst) begin
            stabAge   <= 16'h0000;
            trAge     <= 16'h0000;
            trLoadReg <= 16'h0000;
        end else begin
            stabAge <= tmr[0].start ? 16'h0001 : stabAge + 16'h0001;
            trAge   <= transStart ? 16'h0001 : trAge + 16'h0001;
            if (transStart) begin
                trLoadReg <= transLoad;
            end
        end
    end

    property p_stab;
        tmr[0].done |-> stabAge == ret_pkg::STAB_CYC;
    endproperty
    a_stab: assert property (p_stab) else $error("stabilization event at wrong delay");

    property p_pll;
        pllUnlock && inTx && power_amp_enable |=> status[ret_pkg::EV_PLL];
    endproperty
    a_pll: assert property (p_pll) else $error("PLL unlock not latched");

    property p_vco;
        inTx && $rose(power_amp_enable) && vcoOutRange |=> status[ret_pkg::EV_VCO];
    endproperty
    a_vco: assert property (p_vco) else $error("VCO range fault not latched");

    property p_trans;
        tmr[1].done |-> trAge == trLoadReg && status[ret_pkg::EV_TRANS] == $past(status[ret_pkg::EV_TRANS]) ##1
            status[ret_pkg::EV_TRANS];
    endproperty
    a_trans: assert property (p_trans) else $error("transition event timing wrong");

    // A later command restarts the timer, so only an unbroken wait is judged
    localparam int OFF_RX_DLY = ret_pkg::OFF_RX_US * ret_pkg::CLK_MHZ;
    property p_offrx;
        inRx && offCmd |-> ##OFF_RX_DLY (trAge != 16'(OFF_RX_DLY) || evt[ret_pkg::EV_TRANS]);
    endproperty
    a_offrx: assert property (p_offrx) else $error("radio off from receive not in 4 us");

    property p_fifoerr;
        inRx && fifoOverflow |=> status[ret_pkg::EV_FIFOERR];
    endproperty
    a_fifoerr: assert property (p_fifoerr) else $error("FIFO error not latched");

    property p_syncerr;
        inRx && synced && syncLost && (rx_data_pin_mode == 2'b00 || rx_data_pin_mode == 2'b11)
            |=> status[ret_pkg::EV_SYNCERR];
    endproperty
    a_syncerr: assert property (p_syncerr) else $error("sync error not latched");

    property p_irq;
        (|(status & enable)) [*2] |-> !irq_out_n;
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt output not low");

    property p_latch;
        evt[ret_pkg::EV_FIELD] && !enable[ret_pkg::EV_FIELD] |=> status[ret_pkg::EV_FIELD];
    endproperty
    a_latch: assert property (p_latch) else $error("masked event was not held");

    c_txon: cover property (inTx && tmr[1].done);
    c_rxdone: cover property (evt[ret_pkg::EV_RXDONE]);
    c_irq: cover property ($fell(irq_out_n));
endmodule
`default_nettype wire

// ===== verif/ret_host_model.sv
`default_nettype none
module ret_host_model (
    // Clock and reset
    input  wire logic clock,
    input  wire logic rst,
    // Notification pin
    input  wire logic irq_out_n,
    // Latched observation
    output logic      seen
);
    timeunit 1ns;
    timeprecision 1ps;
    // Sticky so a short low level is not missed between host polls
    always_ff @(posedge clock) begin
        if (rst) begin
            seen <= 1'b0;
        end else if (irq_out_n === 1'b0) begin
            seen <= 1'b1;
        end
    end
endmodule
`default_nettype wire

// ===== verif/ret_event_ctrl_test.sv
`default_nettype none
`define CHK(nm, e, s) begin checked++; if ((s) !== (e)) begin errors++; $display("BAD %s exp %0h got %0h", nm, e, s); end end
module ret_event_ctrl_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clock = 0;
    logic        rst = 1;
    logic [7:0]  paddr = 8'h00;
    logic        psel = 0, penable = 0, pwrite = 0;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic        pready, pslverr, irqN, seen, err;
    logic        pinN = 0, paOn = 0, rxOn = 0, vco = 0, pll = 0;
    logic [10:0] pul = 11'h000;
    logic [7:0]  fifoLvl = 8'h00;
    logic        crcBad = 0;
    int          errors = 0, checked = 0, cyc = 0;
    int          pins[4] = '{3, 4, 5, 6};
    int          bits[4] = '{14, 14, 12, 12};

    always #20 clock = ~clock;

    ret_event_ctrl #(.TX_IDLE_CYC(16'd40), .TX_RX_CYC(16'd20), .RX_IDLE_CYC(16'd40), .RX_TX_CYC(16'd20),
        .WAKE_CYC(16'd30)) DUT (
        .clock(clock), .rst(rst), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .reset_pin_n(pinN),
        .power_amp_enable(paOn), .rxEnable(rxOn), .vcoOutRange(vco), .pllUnlock(pll),
        .syncDetect(pul[0]), .syncLost(pul[1]), .crcBlockDone(pul[2]), .crcBad(crcBad),
        .fieldMatch(pul[3]), .fieldMismatch(pul[4]), .fifoLevel(fifoLvl), .fifoRead(pul[9]),
        .fifoWrite(pul[10]), .fifoOverflow(pul[5]), .fifoUnderflow(pul[6]), .wakeTimerDone(pul[8]),
        .calTimerDone(pul[7]), .irq_out_n(irqN));

    ret_host_model HOST (.clock(clock), .rst(rst), .irq_out_n(irqN), .seen(seen));

    task automatic summarize();
        $display("counts: %0d checked, %0d errors", checked, errors);
        if (errors == 0 && checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        do @(posedge clock); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask

    task automatic pulse(input int i);
        @(posedge clock);
        pul[i] <= 1'b1;
        @(posedge clock);
        pul[i] <= 1'b0;
    endtask

    task automatic wait_n(input int n);
        repeat (n) @(posedge clock);
    endtask

    task automatic clr();
        apb(1'b1, ret_pkg::STATUS_ADDR, 32'h00ffffff);
    endtask

    task automatic st();
        apb(1'b0, ret_pkg::STATUS_ADDR, 32'h0);
    endtask

    always @(posedge clock) begin
        cyc++;
        if (cyc == 20000) begin
            errors++;
            summarize();
        end
    end

    initial begin
        wait_n(8);
        rst <= 1'b0;
        apb(1'b0, ret_pkg::TRIG_ADDR, 32'h0);
        `CHK("trig", {8'h00, ret_pkg::PAYLOAD_RST, ret_pkg::FULL_TRIG_RST, ret_pkg::EMPTY_TRIG_RST}, rd)
        apb(1'b0, ret_pkg::SYMBOL_ADDR, 32'h0);
        `CHK("symbol", {16'h0000, ret_pkg::SYMBOL_RST}, rd)
        apb(1'b0, 8'h1c, 32'h0);
        `CHK("unmapped err", 1'b1, err)
        `CHK("irq idle", 1'b1, irqN)
        $display("test reset done");
        pinN <= 1'b1;
        wait_n(1200);
        st();
        `CHK("stab early", 1'b0, rd[ret_pkg::EV_STAB])
        wait_n(80);
        st();
        `CHK("stab", 1'b1, rd[ret_pkg::EV_STAB])
        $display("test stabilization done");
        apb(1'b1, ret_pkg::SYMBOL_ADDR, 32'h2);
        apb(1'b1, ret_pkg::CMD_ADDR, 32'h1 << ret_pkg::CMD_RX_ON);
        rxOn <= 1'b1;
        wait_n(50);
        apb(1'b0, ret_pkg::STATE_ADDR, 32'h0);
        `CHK("rx state", ret_pkg::R_RX, rd[1:0])
        st();
        `CHK("rx on", 1'b1, rd[ret_pkg::EV_TRANS])
        for (int k = 0; k < 4; k++) begin
            clr();
            pulse(pins[k]);
            st();
            `CHK("immediate event", 1'b1, rd[bits[k]])
        end
        pulse(3);
        `CHK("masked irq", 1'b1, seen | irqN)
        apb(1'b1, ret_pkg::ENABLE_ADDR, 32'h1 << ret_pkg::EV_FIELD);
        wait_n(2);
        `CHK("irq pending", 1'b0, irqN)
        clr();
        wait_n(2);
        `CHK("irq cleared", 1'b1, irqN)
        `CHK("host saw irq", 1'b1, seen)
        $display("test events done");
        apb(1'b1, ret_pkg::CONFIG_ADDR, 32'h7);
        clr();
        pulse(0);
        wait_n(70);
        st();
        `CHK("sync", 1'b1, rd[ret_pkg::EV_SYNC] & rd[ret_pkg::EV_DIV])
        `CHK("full early", 1'b0, rd[ret_pkg::EV_FULL])
        wait_n(20);
        st();
        `CHK("full", 1'b1, rd[ret_pkg::EV_FULL])
        crcBad <= 1'b1;
        pulse(2);
        crcBad <= 1'b0;
        pulse(1);
        st();
        `CHK("sync err", 1'b1, rd[ret_pkg::EV_SYNCERR])
        `CHK("crc block", 1'b1, rd[ret_pkg::EV_CRC])
        apb(1'b1, ret_pkg::CONFIG_ADDR, 32'h5);
        clr();
        pulse(0);
        pulse(1);
        st();
        `CHK("sync err mode 01", 1'b0, rd[ret_pkg::EV_SYNCERR])
        apb(1'b1, ret_pkg::CONFIG_ADDR, 32'h15);
        crcBad <= 1'b1;
        clr();
        pulse(0);
        wait_n(400);
        st();
        `CHK("rx done early", 1'b0, rd[ret_pkg::EV_RXDONE])
        wait_n(50);
        st();
        `CHK("rx done", 1'b1, rd[ret_pkg::EV_RXDONE])
        `CHK("crc at done", 1'b1, rd[ret_pkg::EV_CRC])
        crcBad <= 1'b0;
        clr();
        fifoLvl <= 8'h03;
        wait_n(1);
        fifoLvl <= 8'h01;
        pul[9] <= 1'b1;
        wait_n(1);
        pul[9] <= 1'b0;
        st();
        `CHK("rx empty", 1'b1, rd[ret_pkg::EV_EMPTY])
        $display("test sync done");
        clr();
        apb(1'b1, ret_pkg::CMD_ADDR, 32'h1 << ret_pkg::CMD_TX_ON);
        rxOn <= 1'b0;
        st();
        `CHK("tx early", 1'b0, rd[ret_pkg::EV_TRANS])
        wait_n(25);
        st();
        `CHK("tx from rx", 1'b1, rd[ret_pkg::EV_TRANS])
        vco <= 1'b1;
        paOn <= 1'b1;
        wait_n(2);
        pll <= 1'b1;
        wait_n(1);
        pll <= 1'b0;
        fifoLvl <= 8'h06;
        pul[10] <= 1'b1;
        wait_n(1);
        pul[10] <= 1'b0;
        st();
        `CHK("vco range", 1'b1, rd[ret_pkg::EV_VCO])
        `CHK("pll unlock", 1'b1, rd[ret_pkg::EV_PLL])
        `CHK("tx full", 1'b1, rd[ret_pkg::EV_FULL])
        wait_n(530);
        st();
        `CHK("tx empty early", 1'b0, rd[ret_pkg::EV_EMPTY])
        wait_n(30);
        st();
        `CHK("tx empty", 1'b1, rd[ret_pkg::EV_EMPTY])
        clr();
        apb(1'b1, ret_pkg::CMD_ADDR, 32'h1 << ret_pkg::CMD_OFF);
        wait_n(ret_pkg::OFF_TX_US * ret_pkg::CLK_MHZ + 10);
        st();
        `CHK("off from tx", 1'b1, rd[ret_pkg::EV_TRANS])
        $display("test transmit done");
        apb(1'b1, ret_pkg::CMD_ADDR, 32'h1 << ret_pkg::CMD_RX_ON);
        wait_n(50);
        clr();
        apb(1'b1, ret_pkg::CMD_ADDR, 32'h1 << ret_pkg::CMD_FORCE);
        wait_n(90);
        st();
        `CHK("off rx early", 1'b0, rd[ret_pkg::EV_TRANS])
        wait_n(15);
        st();
        `CHK("off from rx", 1'b1, rd[ret_pkg::EV_TRANS])
        $display("test radio off done");
        apb(1'b1, ret_pkg::CMD_ADDR, 32'h1 << ret_pkg::CMD_CAL);
        pulse(7);
        apb(1'b1, ret_pkg::CMD_ADDR, 32'h1 << ret_pkg::CMD_SLEEP);
        apb(1'b0, ret_pkg::STATE_ADDR, 32'h0);
        `CHK("asleep", ret_pkg::R_SLEEP, rd[1:0])
        pulse(8);
        st();
        `CHK("cal done", 1'b1, rd[ret_pkg::EV_CAL])
        `CHK("wake", 1'b1, rd[ret_pkg::EV_WAKE])
        apb(1'b0, ret_pkg::STATE_ADDR, 32'h0);
        `CHK("awake", ret_pkg::R_IDLE, rd[1:0])
        $display("test sleep done");
        summarize();
    end
endmodule
`default_nettype wire
